// ==== inc/ucrl_pkg.sv ====
// Package with the register map, field positions and carrier types of one serial channel
package ucrl_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;

	// Register addresses
	localparam logic [3:0] ADDR_DATA = 4'h0;
	localparam logic [3:0] ADDR_IER = 4'h1;
	localparam logic [3:0] ADDR_ISR = 4'h2;
	localparam logic [3:0] ADDR_LCR = 4'h3;
	localparam logic [3:0] ADDR_MCR = 4'h4;
	localparam logic [3:0] ADDR_LSR = 4'h5;
	localparam logic [3:0] ADDR_MSR = 4'h6;
	localparam logic [3:0] ADDR_SCR = 4'h7;
	localparam logic [3:0] ADDR_FEATURE_CONTROL = 4'h8;
	localparam logic [3:0] ADDR_EFR = 4'h9;
	localparam logic [3:0] ADDR_TXLVL = 4'ha;
	localparam logic [3:0] ADDR_RXLVL = 4'hb;
	localparam logic [3:0] ADDR_STOP1 = 4'hc;
	localparam logic [3:0] ADDR_STOP2 = 4'hd;
	localparam logic [3:0] ADDR_RES1 = 4'he;
	localparam logic [3:0] ADDR_RES2 = 4'hf;

	// Field positions
	localparam int LCR_DIV_BIT = 7;
	localparam int MCR_DTR_BIT = 0;
	localparam int MCR_RTS_BIT = 1;
	localparam int MCR_OUT1_BIT = 2;
	localparam int MCR_OUT2_BIT = 3;
	localparam int MCR_LOOP_BIT = 4;
	localparam int EFR_ENH_BIT = 4;

	// Bits that only exist while the enhanced enable is set
	localparam logic [7:0] IER_ENH_MASK = 8'he0;
	localparam logic [7:0] ISR_ENH_MASK = 8'h30;
	localparam logic [7:0] FCR_ENH_MASK = 8'h30;
	localparam logic [7:0] MCR_ENH_MASK = 8'he0;

	// Values after reset
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [3:0] FLAG_RST = 4'h0;

	// Software-visible configuration of the channel
	typedef struct packed {
		logic [7:0] dll;
		logic [7:0] divisor_high;
		logic [7:0] divisor_fraction;
		logic [7:0] int_enable;
		logic [7:0] fifo_control;
		logic [7:0] line_control;
		logic [7:0] modem_control;
		logic [7:0] rs485;
		logic [7:0] scratch_pad;
		logic [7:0] feature_control;
		logic [7:0] enhanced_function;
		logic [7:0] tx_fifo_trigger;
		logic [7:0] rx_fifo_trigger;
		logic [7:0] stop1;
		logic [7:0] stop2;
		logic [7:0] res1;
		logic [7:0] res2;
	} ucrl_cfg_type;

	// One host register access
	typedef struct packed {
		logic rd;
		logic wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} ucrl_req_type;

	// Live status from the rest of the channel
	typedef struct packed {
		logic [7:0] rx_data;
		logic [7:0] int_status;
		logic [7:0] line_status;
		logic [7:0] tx_level;
		logic [7:0] rx_level;
	} ucrl_stat_type;

endpackage

// ==== hw/ucrl_regmap.sv ====
// Register map and internal loopback of one serial channel
`timescale 1ns/1ps
module ucrl_regmap (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire ucrl_pkg::ucrl_req_type host_req,
	output logic [7:0] host_rdata,
	output ucrl_pkg::ucrl_cfg_type cfg,
	input wire ucrl_pkg::ucrl_stat_type core_stat,
	output logic thr_wr,
	output logic [7:0] thr_data,
	output logic rx_read,
	output logic fcr_wr,
	output logic tx_fifo_trigger_wr,
	output logic rx_fifo_trigger_wr,
	input wire logic [3:0] flow_evt,
	input wire logic tx_serial,
	output logic rx_serial,
	output logic loopback,
	output logic tx_pin,
	input wire logic rx_pin,
	output logic rts_n,
	output logic dtr_n,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic cd_n,
	input wire logic ri_n
);

	// Read view of a gated register: enhanced bits hide while disabled
	function automatic logic [7:0] gate_rd(input logic [7:0] v, input logic [7:0] m,
		input logic en);
		gate_rd = en ? v : (v & ~m);
	endfunction

	// Write merge: enhanced bits keep their old value while disabled
	function automatic logic [7:0] gate_wr(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] m, input logic en);
		gate_wr = en ? nw : ((old & m) | (nw & ~m));
	endfunction

	ucrl_pkg::ucrl_cfg_type cfg_q, cfg_d;
	logic [7:0] rdata_q, rdata_d, rd_val;
	logic [7:0] thr_data_q, thr_data_d;
	logic thr_wr_q, thr_wr_d, rx_read_q, rx_read_d, fcr_wr_q, fcr_wr_d;
	logic tx_fifo_trigger_wr_q, tx_fifo_trigger_wr_d, rx_fifo_trigger_wr_q, rx_fifo_trigger_wr_d;
	logic [3:0] mstat_q, mstat_d, delta_q, delta_d, mstat_now;
	logic [3:0] flags_q, flags_d;
	logic tx_pin_q, tx_pin_d, rx_ser_q, rx_ser_d, rts_n_q, rts_n_d, dtr_n_q, dtr_n_d;
	logic div_sel, enh, loop_on, msr_rd, xchar_rd;

	assign div_sel = cfg_q.line_control[ucrl_pkg::LCR_DIV_BIT];
	assign enh = cfg_q.enhanced_function[ucrl_pkg::EFR_ENH_BIT];
	assign loop_on = cfg_q.modem_control[ucrl_pkg::MCR_LOOP_BIT];
	assign msr_rd = host_req.rd && (host_req.addr == ucrl_pkg::ADDR_MSR);
	assign xchar_rd = host_req.rd && (host_req.addr == ucrl_pkg::ADDR_STOP1);

	// Modem inputs, bit order cts, dsr, ri, cd; loopback substitutes the control bits
	always_comb begin
		if (loop_on) begin
			mstat_now = {cfg_q.modem_control[ucrl_pkg::MCR_OUT2_BIT], cfg_q.modem_control[ucrl_pkg::MCR_OUT1_BIT],
				cfg_q.modem_control[ucrl_pkg::MCR_DTR_BIT], cfg_q.modem_control[ucrl_pkg::MCR_RTS_BIT]};
		end else begin
			mstat_now = {~cd_n, ~ri_n, ~dsr_n, ~cts_n};
		end
	end

	// Read multiplexer over the sixteen locations
	always_comb begin
		rd_val = ucrl_pkg::REG_RST;
		if (host_req.addr == ucrl_pkg::ADDR_DATA) begin
			rd_val = div_sel ? cfg_q.dll : core_stat.rx_data;
		end else if (host_req.addr == ucrl_pkg::ADDR_IER) begin
			rd_val = div_sel ? cfg_q.divisor_high : gate_rd(cfg_q.int_enable, ucrl_pkg::IER_ENH_MASK, enh);
		end else if (host_req.addr == ucrl_pkg::ADDR_ISR) begin
			rd_val = div_sel ? cfg_q.divisor_fraction : gate_rd(core_stat.int_status, ucrl_pkg::ISR_ENH_MASK, enh);
		end else if (host_req.addr == ucrl_pkg::ADDR_LCR) begin
			rd_val = cfg_q.line_control;
		end else if (host_req.addr == ucrl_pkg::ADDR_MCR) begin
			rd_val = gate_rd(cfg_q.modem_control, ucrl_pkg::MCR_ENH_MASK, enh);
		end else if (host_req.addr == ucrl_pkg::ADDR_LSR) begin
			rd_val = core_stat.line_status;
		end else if (host_req.addr == ucrl_pkg::ADDR_MSR) begin
			rd_val = {mstat_now, delta_q};
		end else if (host_req.addr == ucrl_pkg::ADDR_SCR) begin
			rd_val = cfg_q.scratch_pad;
		end else if (host_req.addr == ucrl_pkg::ADDR_FEATURE_CONTROL) begin
			rd_val = cfg_q.feature_control;
		end else if (host_req.addr == ucrl_pkg::ADDR_EFR) begin
			rd_val = cfg_q.enhanced_function;
		end else if (host_req.addr == ucrl_pkg::ADDR_TXLVL) begin
			rd_val = core_stat.tx_level;
		end else if (host_req.addr == ucrl_pkg::ADDR_RXLVL) begin
			rd_val = core_stat.rx_level;
		end else if (host_req.addr == ucrl_pkg::ADDR_STOP1) begin
			rd_val = {4'h0, flags_q};
		end
		// Addresses 13 to 15 are write-only and read as zero
	end

	// Next state of registers, strobes and flags
	always_comb begin
		cfg_d = cfg_q;
		rdata_d = rdata_q;
		thr_data_d = thr_data_q;
		thr_wr_d = 1'b0;
		rx_read_d = 1'b0;
		fcr_wr_d = 1'b0;
		tx_fifo_trigger_wr_d = 1'b0;
		rx_fifo_trigger_wr_d = 1'b0;
		if (host_req.rd) begin
			rdata_d = rd_val;
			rx_read_d = (host_req.addr == ucrl_pkg::ADDR_DATA) && !div_sel;
		end
		// Writes; the host keeps the divisor bit in step with what it means to reach
		if (host_req.wr) begin
			if (host_req.addr == ucrl_pkg::ADDR_DATA) begin
				if (div_sel) begin
					cfg_d.dll = host_req.wdata;
				end else begin
					thr_wr_d = 1'b1;
					thr_data_d = host_req.wdata;
				end
			end else if (host_req.addr == ucrl_pkg::ADDR_IER) begin
				if (div_sel) begin
					cfg_d.divisor_high = host_req.wdata;
				end else begin
					cfg_d.int_enable = gate_wr(cfg_q.int_enable, host_req.wdata, ucrl_pkg::IER_ENH_MASK, enh);
				end
			end else if (host_req.addr == ucrl_pkg::ADDR_ISR) begin
				if (div_sel) begin
					cfg_d.divisor_fraction = host_req.wdata;
				end else begin
					fcr_wr_d = 1'b1;
					cfg_d.fifo_control = gate_wr(cfg_q.fifo_control, host_req.wdata, ucrl_pkg::FCR_ENH_MASK, enh);
				end
			end else if (host_req.addr == ucrl_pkg::ADDR_LCR) begin
				cfg_d.line_control = host_req.wdata;
			end else if (host_req.addr == ucrl_pkg::ADDR_MCR) begin
				cfg_d.modem_control = gate_wr(cfg_q.modem_control, host_req.wdata, ucrl_pkg::MCR_ENH_MASK, enh);
			end else if (host_req.addr == ucrl_pkg::ADDR_MSR) begin
				if (enh) begin
					cfg_d.rs485 = host_req.wdata;
				end
			end else if (host_req.addr == ucrl_pkg::ADDR_SCR) begin
				cfg_d.scratch_pad = host_req.wdata;
			end else if (host_req.addr == ucrl_pkg::ADDR_FEATURE_CONTROL) begin
				cfg_d.feature_control = host_req.wdata;
			end else if (host_req.addr == ucrl_pkg::ADDR_EFR) begin
				cfg_d.enhanced_function = host_req.wdata;
			end else if (host_req.addr == ucrl_pkg::ADDR_TXLVL) begin
				cfg_d.tx_fifo_trigger = host_req.wdata;
				tx_fifo_trigger_wr_d = 1'b1;
			end else if (host_req.addr == ucrl_pkg::ADDR_RXLVL) begin
				cfg_d.rx_fifo_trigger = host_req.wdata;
				rx_fifo_trigger_wr_d = 1'b1;
			end else if (host_req.addr == ucrl_pkg::ADDR_STOP1) begin
				cfg_d.stop1 = host_req.wdata;
			end else if (host_req.addr == ucrl_pkg::ADDR_STOP2) begin
				cfg_d.stop2 = host_req.wdata;
			end else if (host_req.addr == ucrl_pkg::ADDR_RES1) begin
				cfg_d.res1 = host_req.wdata;
			end else begin
				cfg_d.res2 = host_req.wdata;
			end
		end
		// Sticky flags: a new event beats the clear-on-read in the same cycle
		mstat_d = mstat_now;
		delta_d = (delta_q & ~{4{msr_rd}}) | (mstat_now ^ mstat_q);
		flags_d = (flags_q & ~{4{xchar_rd}}) | flow_evt;
	end

	// Pin steering; registered so the pins never glitch while the mode bit flips
	always_comb begin
		tx_pin_d = loop_on ? 1'b1 : tx_serial;
		rx_ser_d = loop_on ? tx_serial : rx_pin;
		rts_n_d = loop_on ? 1'b1 : ~cfg_q.modem_control[ucrl_pkg::MCR_RTS_BIT];
		dtr_n_d = loop_on ? 1'b1 : ~cfg_q.modem_control[ucrl_pkg::MCR_DTR_BIT];
	end

	// State registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= '0;
			rdata_q <= ucrl_pkg::REG_RST;
			thr_data_q <= ucrl_pkg::REG_RST;
			thr_wr_q <= 1'b0;
			rx_read_q <= 1'b0;
			fcr_wr_q <= 1'b0;
			tx_fifo_trigger_wr_q <= 1'b0;
			rx_fifo_trigger_wr_q <= 1'b0;
			mstat_q <= ucrl_pkg::FLAG_RST;
			delta_q <= ucrl_pkg::FLAG_RST;
			flags_q <= ucrl_pkg::FLAG_RST;
			tx_pin_q <= 1'b1;
			rx_ser_q <= 1'b1;
			rts_n_q <= 1'b1;
			dtr_n_q <= 1'b1;
		end else begin
			cfg_q <= cfg_d;
			rdata_q <= rdata_d;
			thr_data_q <= thr_data_d;
			thr_wr_q <= thr_wr_d;
			rx_read_q <= rx_read_d;
			fcr_wr_q <= fcr_wr_d;
			tx_fifo_trigger_wr_q <= tx_fifo_trigger_wr_d;
			rx_fifo_trigger_wr_q <= rx_fifo_trigger_wr_d;
			mstat_q <= mstat_d;
			delta_q <= delta_d;
			flags_q <= flags_d;
			tx_pin_q <= tx_pin_d;
			rx_ser_q <= rx_ser_d;
			rts_n_q <= rts_n_d;
			dtr_n_q <= dtr_n_d;
		end
	end

	// Outputs
	assign host_rdata = rdata_q;
	assign cfg = cfg_q;
	assign thr_wr = thr_wr_q;
	assign thr_data = thr_data_q;
	assign rx_read = rx_read_q;
	assign fcr_wr = fcr_wr_q;
	assign tx_fifo_trigger_wr = tx_fifo_trigger_wr_q;
	assign rx_fifo_trigger_wr = rx_fifo_trigger_wr_q;
	assign loopback = loop_on;
	assign tx_pin = tx_pin_q;
	assign rx_serial = rx_ser_q;
	assign rts_n = rts_n_q;
	assign dtr_n = dtr_n_q;

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_loop_enter;
		host_req.wr && (host_req.addr == ucrl_pkg::ADDR_MCR)
			|=> loopback == $past(host_req.wdata[4]);
	endproperty
	a_loop_enter: assert property (p_loop_enter) else $error("loop bit not taken");

	property p_loop_rx;
		loopback |=> rx_serial == $past(tx_serial);
	endproperty
	a_loop_rx: assert property (p_loop_rx) else $error("loopback rx path wrong");

	property p_loop_tx;
		loopback ##1 loopback |-> tx_pin;
	endproperty
	a_loop_tx: assert property (p_loop_tx) else $error("tx pin not at mark");

	property p_loop_modem;
		loopback |=> rts_n && dtr_n;
	endproperty
	a_loop_modem: assert property (p_loop_modem) else $error("modem outputs active");

	property p_loop_ignore;
		loopback && host_req.rd && (host_req.addr == ucrl_pkg::ADDR_MSR)
			|=> host_rdata[4] == $past(cfg_q.modem_control[1]) && host_rdata[5] == $past(cfg_q.modem_control[0]);
	endproperty
	a_loop_ignore: assert property (p_loop_ignore) else $error("modem pins seen");

	property p_thr;
		host_req.wr && (host_req.addr == ucrl_pkg::ADDR_DATA) && !div_sel
			|=> thr_wr && thr_data == $past(host_req.wdata) ##1 !thr_wr || $past(host_req.wr);
	endproperty
	a_thr: assert property (p_thr) else $error("holding write lost");

	property p_div;
		host_req.wr && (host_req.addr == ucrl_pkg::ADDR_DATA) && div_sel
			|=> cfg.dll == $past(host_req.wdata) && !thr_wr;
	endproperty
	a_div: assert property (p_div) else $error("divisor write wrong");

	property p_rs485;
		host_req.wr && (host_req.addr == ucrl_pkg::ADDR_MSR) && !enh |=> $stable(cfg.rs485);
	endproperty
	a_rs485: assert property (p_rs485) else $error("gated write taken");

	property p_enh_rd;
		!enh && host_req.rd && (host_req.addr == ucrl_pkg::ADDR_MCR)
			|=> host_rdata[7:5] == 3'h0;
	endproperty
	a_enh_rd: assert property (p_enh_rd) else $error("gated bits visible");

	property p_scratch;
		host_req.wr && (host_req.addr == ucrl_pkg::ADDR_SCR)
			##1 (host_req.rd && !host_req.wr && host_req.addr == ucrl_pkg::ADDR_SCR)
			|=> host_rdata == $past(host_req.wdata, 2);
	endproperty
	a_scratch: assert property (p_scratch) else $error("scratch lost");

	property p_txlvl;
		host_req.rd && (host_req.addr == ucrl_pkg::ADDR_TXLVL) |=> host_rdata == $past(core_stat.tx_level);
	endproperty
	a_txlvl: assert property (p_txlvl) else $error("tx level wrong");

	property p_flag_set;
		flow_evt[0] |=> flags_q[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flow event lost");

	c_loop: cover property (loopback && thr_wr);
	c_div: cover property (div_sel && host_req.wr && host_req.addr == ucrl_pkg::ADDR_ISR);
	c_msr: cover property (msr_rd && |delta_q);
	c_exit: cover property (loopback ##1 !loopback);

endmodule // ucrl_regmap

// ==== bench/ucrl_modem_model.sv ====
// Remote modem model that echoes the serial line and drives modem status pins
`timescale 1ns/1ps
module ucrl_modem_model (
	input wire logic ref_clk,
	input wire logic slow,
	input wire logic tx_pin,
	input wire logic [3:0] status_n,
	output logic rx_pin,
	output logic cts_n,
	output logic dsr_n,
	output logic cd_n,
	output logic ri_n
);
	logic [1:0] echo_q;
	// Echo delay line, so a slow modem answers two cycles late
	always_ff @(posedge ref_clk) begin
		echo_q <= {echo_q[0], tx_pin};
	end
	// Prompt echo is wired straight through; slow mode only after the line has been clocked
	assign rx_pin = slow ? echo_q[1] : tx_pin;
	assign {cd_n, ri_n, dsr_n, cts_n} = status_n;
endmodule // ucrl_modem_model

// ==== bench/tb_top.sv ====
// Self-checking testbench for the channel register map and loopback
`timescale 1ns/1ps
module tb_top;
	logic ref_clk, rst_n, tx_serial, slow, thr_wr, rx_read, fcr_wr, tx_fifo_trigger_wr, rx_fifo_trigger_wr;
	logic rx_serial, loopback, tx_pin, rx_pin, rts_n, dtr_n, cts_n, dsr_n, cd_n, ri_n;
	logic [7:0] host_rdata, thr_data, v, r, m;
	logic [3:0] flow_evt, status_n;
	logic [31:0] seed = 32'hf770;
	ucrl_pkg::ucrl_req_type host_req;
	ucrl_pkg::ucrl_stat_type core_stat;
	ucrl_pkg::ucrl_cfg_type cfg;
	int n_mismatch = 0;
	int num_checks = 0;

	ucrl_regmap u_ucrl_regmap (.ref_clk, .rst_n, .host_req, .host_rdata, .cfg, .core_stat,
		.thr_wr, .thr_data, .rx_read, .fcr_wr, .tx_fifo_trigger_wr, .rx_fifo_trigger_wr, .flow_evt, .tx_serial,
		.rx_serial, .loopback, .tx_pin, .rx_pin, .rts_n, .dtr_n, .cts_n, .dsr_n, .cd_n, .ri_n);
	ucrl_modem_model u_ucrl_modem_model (.ref_clk, .slow, .tx_pin, .status_n, .rx_pin,
		.cts_n, .dsr_n, .cd_n, .ri_n);

	// Free-running 40 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// Fixed-seed LFSR keeps every run identical
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	// Gated enhanced bits read as zero while the enable is clear
	function automatic logic [7:0] gate(input logic [7:0] d, input logic [7:0] mk, input int e);
		return (e != 0) ? d : (d & ~mk);
	endfunction
	// In loopback the status nibble comes from the control bits
	function automatic logic [3:0] msr_exp(input logic [7:0] c);
		return {c[3], c[2], c[0], c[1]};
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Bus cycles: one-cycle strobe, result visible one edge later
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		host_req.wr = 1'b1;
		host_req.addr = a;
		host_req.wdata = d;
		@(negedge ref_clk);
		host_req.wr = 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		host_req.rd = 1'b1;
		host_req.addr = a;
		@(negedge ref_clk);
		host_req.rd = 1'b0;
		d = host_rdata;
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Watchdog sized well above the roughly 215 cycles the sequence needs
	initial begin
		#(25 * 8000);
		n_mismatch++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		host_req = '0;
		core_stat = '0;
		flow_evt = 4'h0;
		tx_serial = 1'b1;
		slow = 1'b0;
		status_n = 4'hf;
		rst_n = 1'b0;
		repeat (3) @(negedge ref_clk);
		rst_n = 1'b1;
		check(8'({loopback, tx_pin, rts_n, dtr_n}), 8'h07);
		repeat (3) begin
			for (int i = 0; i < 10; i++) begin
				v = rnd();
				if (i == 3) v[7] = 1'b0;
				if (i == 3 || i == 7 || i == 8 || i == 9) begin
					wr(i[3:0], v);
					rd(i[3:0], r);
					check(r, v);
				end
			end
		end
		// Host opens the divisor window only around divisor access
		wr(4'h9, 8'h00);
		wr(4'h3, 8'h80);
		for (int a = 0; a < 3; a++) begin
			v = rnd();
			wr(a[3:0], v);
			rd(a[3:0], r);
			check(r, v);
		end
		check(cfg.divisor_fraction, v);
		wr(4'h3, 8'h03);
		v = rnd();
		wr(4'h0, v);
		check(8'({thr_wr, fcr_wr}), 8'h02);
		check(thr_data, v);
		core_stat = {rnd(), rnd(), rnd(), rnd(), rnd()};
		rd(4'h0, r);
		check(r, core_stat.rx_data);
		check(8'(rx_read), 8'h01);
		// Enhanced gating, first closed then open
		for (int e = 0; e < 2; e++) begin
			wr(4'h9, (e != 0) ? 8'h10 : 8'h00);
			v = rnd();
			wr(4'h1, v);
			rd(4'h1, r);
			check(r, gate(v, 8'he0, e));
			rd(4'h2, r);
			check(r, gate(core_stat.int_status, 8'h30, e));
			wr(4'h2, v);
			check(8'(fcr_wr), 8'h01);
			wr(4'h6, v);
			check(cfg.rs485, (e != 0) ? v : 8'h00);
			wr(4'h4, v & 8'hef);
			rd(4'h4, r);
			check(r, gate(v & 8'hef, 8'he0, e));
		end
		rd(4'h5, r);
		check(r, core_stat.line_status);
		rd(4'ha, r);
		check(r, core_stat.tx_level);
		rd(4'hb, r);
		check(r, core_stat.rx_level);
		for (int k = 0; k < 2; k++) begin
			v = rnd();
			wr(4'ha + k[3:0], v);
			check((k != 0) ? cfg.rx_fifo_trigger : cfg.tx_fifo_trigger, v);
			check(8'((k != 0) ? rx_fifo_trigger_wr : tx_fifo_trigger_wr), 8'h01);
		end
		// Flow flags are read once, then self-clear
		@(negedge ref_clk);
		flow_evt = 4'ha;
		@(negedge ref_clk);
		flow_evt = 4'h0;
		rd(4'hc, r);
		check(r, 8'h0a);
		rd(4'hc, r);
		check(r, 8'h00);
		for (int k = 0; k < 4; k++) begin
			v = rnd();
			wr(4'hc + k[3:0], v);
			check(cfg[8 * (3 - k) +: 8], v);
		end
		rd(4'hd, r);
		check(r, 8'h00);
		// Loopback with a slow partner and random pin noise
		slow = 1'b1;
		for (int k = 0; k < 8; k++) begin
			m = 8'h10 | (rnd() & 8'h0f);
			wr(4'h4, m);
			v = rnd();
			status_n = v[3:0];
			tx_serial = v[4];
			repeat (2) @(negedge ref_clk);
			check(8'({loopback, tx_pin, rts_n, dtr_n, rx_serial}), {3'h0, 4'hf, v[4]});
			rd(4'h6, r);
			check(8'(r[7:4]), 8'(msr_exp(m)));
			wr(4'h7, v);
			rd(4'h7, r);
			check(r, v);
		end
		wr(4'h4, 8'h00);
		tx_serial = 1'b0;
		repeat (2) @(negedge ref_clk);
		check(8'({loopback, tx_pin, rts_n, dtr_n}), 8'h03);
		tally_and_finish();
	end
endmodule // tb_top
